// file: fbp_defines.vh
// register offsets, field positions, reset values for the four-bit port
// assumes inclusion by bare name from the design files
`ifndef FBP_DEFINES_VH
`define FBP_DEFINES_VH
`define FBP_ADDR_W 2
`define FBP_OFS_PIN 2'h0
`define FBP_OFS_LAT 2'h1
`define FBP_OFS_DIR 2'h2
`define FBP_OFS_SLV 2'h3
`define FBP_BIT_IBF 7
`define FBP_BIT_OBF 6
`define FBP_BIT_INPUT_OVERFLOW_FLAG 5
`define FBP_BIT_PSP 4
`define FBP_DIR_RESET 3'h7
`define FBP_LAT_RESET 3'h0
`define FBP_SLV_RESET 8'h00
`endif

// file: fbp_slave_ctl.v
// slave port strobe decoder: detects end of external writes, start and end of external reads
// assumes strobes are synchronous to clock_in and active low
`default_nettype none
module fbp_slave_ctl (
  // clock and reset
  input wire clock_in,
  input wire srst_in,
  // strobes
  input wire enable_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire cs_n_in,
  // events
  output reg wr_end_out,
  output reg rd_start_out,
  output reg rd_end_out
);
  reg wr_act_reg;
  reg rd_act_reg;
  wire wr_low;
  wire rd_low;
  assign wr_low = enable_in & ~cs_n_in & ~wr_n_in;
  assign rd_low = enable_in & ~cs_n_in & ~rd_n_in;
  always @(posedge clock_in) begin
    if (srst_in) begin
      wr_act_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      wr_end_out <= 1'b0;
      rd_start_out <= 1'b0;
      rd_end_out <= 1'b0;
    end else begin
      wr_act_reg <= wr_low;
      rd_act_reg <= rd_low;
      wr_end_out <= wr_act_reg & ~wr_low; // RULE20
      rd_start_out <= rd_low & ~rd_act_reg; // RULE21
      rd_end_out <= rd_act_reg & ~rd_low;
    end
  end
endmodule // fbp_slave_ctl
`default_nettype wire

// file: fbp_port.v
// four-bit port: pins, output latch, direction and slave status register
// assumes a one-cycle register port master and synchronous pin inputs
//
// Operation
// [RULE1] wide variant has four bits, three with own direction
// [RULE2] analog-selected pins read zero in pin data
// [RULE3] direction one tristates driver, pin is input
// [RULE4] direction zero drives latch onto the pin
// [RULE5] direction still governs drivers in analog mode
// [RULE6] software keeps analog pins as inputs
// [RULE7] after reset three pins are analog inputs
// [RULE8] latch register reads back latch, not pin level
// [RULE9] master clear enable zero makes fourth pin a plain input
// [RULE10] small variant has only the fourth input bit
// [RULE11] pin data bit 3 exists only with master clear disabled
// [RULE12] status resets 7:4 zero, 2:0 one; bit 3 zero; 7,6 read-only
// [RULE13] bit 7 set while received word unread
// [RULE14] bit 6 set while written word not yet read externally
// [RULE15] bit 5 set on overrun write, cleared only by software
// [RULE16] bit 4 selects slave port mode
// [RULE17] slave mode uses pins 0,1,2 as read, write, chip select
// [RULE18] output pin keeps driving latch when analog selected
// [RULE19] pin data bits 7:4 read zero, 3:0 are the pins
// [RULE20] external write ends on strobe high, sets input full and irq
// [RULE21] external read outputs data and clears output full
// [RULE22] analog select comes from configuration input, gates inputs
`include "fbp_defines.vh"
`default_nettype none
module fbp_port #(
  parameter WIDE_VARIANT = 1
) (
  // clock and reset
  input wire clock_in,
  input wire srst_in,
  // register port
  input wire [`FBP_ADDR_W-1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // configuration
  input wire master_clear_enable_cfg_in,
  input wire [2:0] analog_select_in,
  // pins
  input wire [2:0] pin_in,
  output reg [2:0] pin_out,
  output reg [2:0] pin_oe_n_out,
  input wire fourth_input_pin_in,
  output reg master_clear_out,
  // slave port side
  input wire slave_data_wr_in,
  output reg slave_port_irq_flag_out,
  output reg slave_drive_out
);
  reg [2:0] latch_reg;
  reg [2:0] dir_reg;
  reg input_full_flag_reg;
  reg output_full_flag_reg;
  reg input_overflow_flag_reg;
  reg slave_port_select_reg;
  reg [7:0] rdata_next;
  wire [3:0] pin_data;
  wire [7:0] status_val;
  wire slave_en;
  wire wr_end;
  wire rd_start;
  wire rd_end;
  wire wr_pin;
  wire wr_lat;
  wire wr_dir;
  wire wr_slv;
  wire rd_slv;
  genvar i;

  function sel;
    input [`FBP_ADDR_W-1:0] a;
    input [`FBP_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode
  assign wr_pin = reg_wr_in & sel(reg_addr_in, `FBP_OFS_PIN);
  assign wr_lat = reg_wr_in & sel(reg_addr_in, `FBP_OFS_LAT);
  assign wr_dir = reg_wr_in & sel(reg_addr_in, `FBP_OFS_DIR);
  assign wr_slv = reg_wr_in & sel(reg_addr_in, `FBP_OFS_SLV);
  assign rd_slv = reg_rd_in & sel(reg_addr_in, `FBP_OFS_SLV);

  ////////////////////////////////////////////////////////////////////
  // pin input path
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_pin
      // analog select gates digital input
      assign pin_data[i] = (WIDE_VARIANT != 0) &
        ~analog_select_in[i] & pin_in[i]; // RULE2 RULE22 RULE1 RULE10
    end
  endgenerate
  assign pin_data[3] = ~master_clear_enable_cfg_in &
    fourth_input_pin_in; // RULE9 RULE11

  // slave mode needs all three pins as inputs
  assign slave_en = (WIDE_VARIANT != 0) & slave_port_select_reg &
    (&dir_reg); // RULE16 RULE17

  fbp_slave_ctl u_slave_ctl (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .enable_in(slave_en),
    .rd_n_in(pin_in[0]),
    .wr_n_in(pin_in[1]),
    .cs_n_in(pin_in[2]),
    .wr_end_out(wr_end),
    .rd_start_out(rd_start),
    .rd_end_out(rd_end)
  ); // RULE17

  ////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clock_in) begin
    if (srst_in) begin
      latch_reg <= `FBP_LAT_RESET;
      dir_reg <= `FBP_DIR_RESET; // RULE7 RULE12
      slave_port_select_reg <= 1'b0; // RULE12
    end else begin
      if (wr_pin | wr_lat)
        latch_reg <= reg_wdata_in[2:0]; // RULE8
      if (wr_dir) begin
        dir_reg <= reg_wdata_in[2:0];
        slave_port_select_reg <= reg_wdata_in[`FBP_BIT_PSP]; // RULE16
      end
    end
  end

  // status flags: set wins over clear; output full is set by software and cleared by hardware
  always @(posedge clock_in) begin
    if (srst_in) begin
      input_full_flag_reg <= 1'b0;
      output_full_flag_reg <= 1'b0;
      input_overflow_flag_reg <= 1'b0;
      slave_port_irq_flag_out <= 1'b0;
    end else begin
      if (wr_end)
        input_full_flag_reg <= 1'b1; // RULE13 RULE20
      else if (rd_slv)
        input_full_flag_reg <= 1'b0; // RULE13
      if (wr_slv & slave_en)
        output_full_flag_reg <= 1'b1; // RULE14
      else if (rd_start)
        output_full_flag_reg <= 1'b0; // RULE14 RULE21
      if (wr_end & input_full_flag_reg)
        input_overflow_flag_reg <= 1'b1; // RULE15
      else if (wr_dir & ~reg_wdata_in[`FBP_BIT_INPUT_OVERFLOW_FLAG])
        input_overflow_flag_reg <= 1'b0; // RULE15
      slave_port_irq_flag_out <= wr_end | rd_end; // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin drivers and side outputs
  always @(posedge clock_in) begin
    if (srst_in) begin
      pin_out <= `FBP_LAT_RESET;
      pin_oe_n_out <= 3'h7;
      master_clear_out <= 1'b0;
      slave_drive_out <= 1'b0;
    end else begin
      // direction wins regardless of analog select
      pin_out <= latch_reg; // RULE4 RULE18
      pin_oe_n_out <= (WIDE_VARIANT != 0) ? dir_reg :
        3'h7; // RULE3 RULE5
      master_clear_out <= master_clear_enable_cfg_in &
        ~fourth_input_pin_in; // RULE9
      if (rd_start)
        slave_drive_out <= 1'b1; // RULE21
      else if (rd_end | ~slave_en)
        slave_drive_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux
  assign status_val = {input_full_flag_reg, output_full_flag_reg,
    input_overflow_flag_reg, slave_port_select_reg, 1'b0,
    dir_reg}; // RULE12

  always @* begin
    rdata_next = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `FBP_OFS_PIN: rdata_next = {4'h0, pin_data}; // RULE19
        `FBP_OFS_LAT: rdata_next = {5'h00, latch_reg}; // RULE8
        `FBP_OFS_DIR: rdata_next = status_val;
        `FBP_OFS_SLV: rdata_next = {7'h00, slave_data_wr_in};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always @(posedge clock_in) begin
    if (srst_in)
      reg_rdata_out <= 8'h00;
    else
      reg_rdata_out <= rdata_next;
  end
endmodule // fbp_port
`default_nettype wire

// file: fbp_port_checker.sv
// checker for the four-bit port, bound into fbp_port
// assumes one-cycle register strobes and a sync active-high reset
`default_nettype none
module fbp_port_checker (
  // clock, reset, register port
  input wire clock_in,
  input wire srst_in,
  input wire [1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // configuration and pins
  input wire master_clear_enable_cfg_in,
  input wire [2:0] analog_select_in,
  input wire [2:0] pin_out,
  input wire [2:0] pin_oe_n_out,
  input wire master_clear_out,
  input wire slave_port_irq_flag_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  wire rd0 = reg_rd_in && reg_addr_in == 2'h0;
  property p_idle; !$past(reg_rd_in) |-> reg_rdata_out == 8'h00; endproperty
  property p_rst; $fell(srst_in) |-> pin_oe_n_out == 3'h7; endproperty
  property p_ana;
    rd0 && analog_select_in == 3'h7 && $stable(analog_select_in)
      |=> reg_rdata_out[2:0] == 3'h0;
  endproperty
  property p_master_clear_input_bit;
    rd0 && master_clear_enable_cfg_in |=> !reg_rdata_out[3];
  endproperty
  property p_pin_hi; rd0 |=> reg_rdata_out[7:4] == 4'h0; endproperty
  property p_st_b3;
    reg_rd_in && reg_addr_in == 2'h2 |=> !reg_rdata_out[3];
  endproperty
  property p_master_clear_input; !master_clear_enable_cfg_in [*2] |-> !master_clear_out;
  endproperty
  property p_irq; $rose(slave_port_irq_flag_out) |=> !slave_port_irq_flag_out;
  endproperty
  property p_dir;
    reg_wr_in && reg_addr_in == 2'h2 ##1 !reg_wr_in [*2]
      |-> pin_oe_n_out == $past(reg_wdata_in[2:0], 2);
  endproperty
  property p_lat;
    reg_wr_in && reg_addr_in == 2'h1 ##1 !reg_wr_in [*2]
      |-> pin_out == $past(reg_wdata_in[2:0], 2);
  endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  a_rst: assert property (p_rst) else $error("pins not inputs");
  a_ana: assert property (p_ana) else $error("analog pin not 0");
  a_master_clear_input_bit: assert property (p_master_clear_input_bit) else $error("bit3 live");
  a_pin_hi: assert property (p_pin_hi) else $error("pin data top");
  a_st_b3: assert property (p_st_b3) else $error("status bit3");
  a_master_clear_input: assert property (p_master_clear_input) else $error("clear while off");
  a_irq: assert property (p_irq) else $error("irq too long");
  a_dir: assert property (p_dir) else $error("enable mismatch");
  a_lat: assert property (p_lat) else $error("pin drive mismatch");
  c_irq: cover property ($rose(slave_port_irq_flag_out));
  c_ana: cover property (rd0 && analog_select_in == 3'h7);
  c_dir: cover property (reg_wr_in && reg_addr_in == 2'h2);
endmodule // fbp_port_checker
bind fbp_port fbp_port_checker u_fbp_port_checker (.clock_in, .srst_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .master_clear_enable_cfg_in, .analog_select_in, .pin_out, .pin_oe_n_out,
  .master_clear_out, .slave_port_irq_flag_out);
`default_nettype wire

// file: fbp_pin_board.sv
// board side of the three port pins, pulled up when undriven
// assumes enable low means the port drives the pin
`default_nettype none
module fbp_pin_board (
  // from the port
  input wire logic [2:0] port_data_in,
  input wire logic [2:0] port_oe_n_in,
  // board pull-downs, level at the port
  input wire logic [2:0] pull_low_in,
  output logic [2:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!port_oe_n_in[i]) pin_level_out[i] = port_data_in[i];
      else pin_level_out[i] = !pull_low_in[i];
    end
  end
endmodule // fbp_pin_board
`default_nettype wire

// file: four_bit_port_with_slave_status_tb_top.sv
// self-checking bench for the four-bit port
// assumes the pin board model and the bound checker
`default_nettype none
module four_bit_port_with_slave_status_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 0, srst_in = 1, reg_wr = 0, reg_rd = 0, mcfg = 0;
  logic fourth = 1, master_clear_input, irq, sdrv, drv_seen = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic [2:0] analog = 0, pull = 0, lvl, pout, poe_n;
  int failures = 0, total_checks = 0, cyc = 0, irqs = 0;
  typedef struct {logic [1:0] a; logic [7:0] d; logic [7:0] e;} fbp_row_t;
  fbp_row_t rows [5] = '{'{2'h1, 8'hff, 8'h07}, '{2'h1, 8'h05, 8'h05},
    '{2'h2, 8'hff, 8'h17}, '{2'h2, 8'h00, 8'h00}, '{2'h0, 8'h02, 8'h0a}};
  fbp_port #(.WIDE_VARIANT(1)) u_fbp_port (.clock_in(clock_in),
    .srst_in(srst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .master_clear_enable_cfg_in(mcfg), .analog_select_in(analog),
    .pin_in(lvl), .pin_out(pout), .pin_oe_n_out(poe_n),
    .fourth_input_pin_in(fourth), .master_clear_out(master_clear_input),
    .slave_data_wr_in(1'b0), .slave_port_irq_flag_out(irq),
    .slave_drive_out(sdrv));
  fbp_pin_board u_fbp_pin_board (.port_data_in(pout), .port_oe_n_in(poe_n),
    .pull_low_in(pull), .pin_level_out(lvl));
  initial forever #20 clock_in = ~clock_in;
  task automatic final_report();
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (sdrv === 1'b1) drv_seen <= 1;
    if (cyc == 2000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc1(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_wr <= w;
    reg_rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
  endtask
  task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
    cyc1(0, a, 8'h00);
    chk(rdata, e);
  endtask
  task automatic ext(input logic [2:0] lows);
    @(posedge clock_in);
    pull <= lows;
    repeat (3) @(posedge clock_in);
    pull <= 3'h0;
    repeat (4) @(posedge clock_in);
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    srst_in <= 0;
    #1 chk({5'h0, poe_n}, 8'h07);
    rdchk(2'h2, 8'h07);
    foreach (rows[i]) begin
      cyc1(1, rows[i].a, rows[i].d);
      repeat (4) @(posedge clock_in);
      rdchk(rows[i].a, rows[i].e);
    end
    analog <= 3'h7;
    cyc1(1, 2'h1, 8'h07);
    repeat (4) @(posedge clock_in);
    #1 chk({5'h0, pout}, 8'h07);
    chk({5'h0, poe_n}, 8'h00);
    rdchk(2'h0, 8'h08);
    mcfg <= 1;
    fourth <= 0;
    repeat (3) @(posedge clock_in);
    #1 chk({7'h0, master_clear_input}, 8'h01);
    fourth <= 1;
    rdchk(2'h0, 8'h00);
    mcfg <= 0;
    analog <= 3'h0;
    cyc1(1, 2'h2, 8'h17);
    ext(3'b110);
    rdchk(2'h2, 8'h97);
    ext(3'b110);
    rdchk(2'h2, 8'hb7);
    cyc1(1, 2'h2, 8'h17);
    rdchk(2'h2, 8'h97);
    cyc1(0, 2'h3, 8'h00);
    rdchk(2'h2, 8'h17);
    cyc1(1, 2'h3, 8'h55);
    rdchk(2'h2, 8'h57);
    ext(3'b101);
    chk({7'h0, drv_seen}, 8'h01);
    rdchk(2'h2, 8'h17);
    chk(irqs[7:0], 8'h03);
    srst_in <= 1;
    repeat (2) @(posedge clock_in);
    srst_in <= 0;
    #1 chk({5'h0, poe_n}, 8'h07);
    rdchk(2'h2, 8'h07);
    final_report();
  end
endmodule // four_bit_port_with_slave_status_tb_top
`default_nettype wire
